// >>> common/ebt_pkg.sv
// Constants shared by the eight-bit timer with shared prescaler
package ebt_pkg;
  // Register offsets on the plain register port
  localparam logic [1:0] ADDR_CONFIG  = 2'h0;
  localparam logic [1:0] ADDR_INTCTL  = 2'h1;
  localparam logic [1:0] ADDR_COUNT   = 2'h2;
  localparam logic [1:0] ADDR_WDSTAT  = 2'h3;
  // Field positions of timer_config_reg
  localparam int CFG_SRC_BIT    = 5;
  localparam int CFG_EDGE_BIT   = 4;
  localparam int CFG_ASSIGN_BIT = 3;
  localparam int CFG_RATE_LSB   = 0;
  // Field positions of interrupt_control_reg
  localparam int ICR_IE_BIT     = 5;
  localparam int ICR_IF_BIT     = 2;
  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'hFF;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  // Instruction cycle is four oscillator clocks
  localparam logic [1:0] PHASE_LAST   = 2'h3;
  localparam logic [1:0] PHASE_TWO    = 2'h1;
  localparam logic [1:0] PHASE_FOUR   = 2'h3;
  // Instruction cycles inhibited after a count write
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
  localparam int PRESCALE_WIDTH = 8;
  localparam int WATCHDOG_WIDTH = 16;
endpackage

// >>> core/ebt_prescaler.sv
// Shared 8-bit ripple-style prescaler with rate tap selection
`timescale 1ns/1ps
module ebt_prescaler #(
  parameter int WIDTH = ebt_pkg::PRESCALE_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             tick,
  input  wire logic             clear,
  input  wire logic [2:0]       rate,
  input  wire logic             forWatchdog,
  output logic                  tapOut
);
  import ebt_pkg::*;

  logic [WIDTH-1:0] count_reg;
  logic [3:0]       tapIndex;
  logic [WIDTH-1:0] tapMask;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_reg <= '0;
    else if (clear)
      count_reg <= '0;
    else if (tick)
      count_reg <= count_reg + WIDTH'(1);
  end

  // Timer taps one stage later than the watchdog for the same code
  always_comb
  begin
    tapIndex = {1'b0, rate} + {3'h0, ~forWatchdog};
    tapMask  = (WIDTH'(1) << tapIndex) - WIDTH'(1);
    // Divide by 2^k fires on the tick that completes the low k bits; k of 0 passes every tick
    tapOut   = tick && ((count_reg & tapMask) == tapMask);
  end
endmodule // ebt_prescaler

// >>> core/ebt_timer.sv
// Eight-bit timer/counter with prescaler shared with the watchdog
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module ebt_timer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  input  wire logic       extCountInput,
  input  wire logic       watchdogClearInstr,
  input  wire logic       sleepMode,
  output logic            timerIrq,
  output logic            watchdogTimeout
);
  import ebt_pkg::*;

  logic [7:0]  timerConfig_reg;
  logic [7:0]  interruptControl_reg;
  logic [7:0]  timerCount_reg;
  logic [1:0]  phase_reg;
  logic [1:0]  inhibit_reg;
  logic        extSample_reg;
  logic        extPrev_reg;
  logic [WATCHDOG_WIDTH-1:0] watchdog_reg;
  logic        timeout_reg;
  logic        irq_reg;
  logic [7:0]  rdData_reg;
  logic [1:0]  ticksSinceWrite_reg;

  logic        countSource;
  logic        edgeSelect;
  logic        assignWatchdog;
  logic [2:0]  rate;
  logic        instrTick;
  logic        extEdge;
  logic        sourceEvent;
  logic        preTick;
  logic        preClear;
  logic        preOut;
  logic        countEvent;
  logic        watchdogTick;
  logic        countWrite;
  logic        overflow;

  assign countSource    = timerConfig_reg[CFG_SRC_BIT];
  assign edgeSelect     = timerConfig_reg[CFG_EDGE_BIT];
  assign assignWatchdog = timerConfig_reg[CFG_ASSIGN_BIT];
  assign rate           = timerConfig_reg[CFG_RATE_LSB +: 3];
  assign countWrite     = wrStrobe && (addr == ADDR_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // Phase clock: four oscillator clocks per instruction cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      phase_reg <= 2'h0;
    else if (!sleepMode)
      phase_reg <= phase_reg + 2'h1;
  end

  assign instrTick = !sleepMode && (phase_reg == PHASE_LAST);

  // External input is sampled only on phase two and phase four
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      extSample_reg <= 1'b0;
      extPrev_reg   <= 1'b0;
    end
    else if (!sleepMode && (phase_reg == PHASE_TWO || phase_reg == PHASE_FOUR))
    begin
      extSample_reg <= extCountInput;
      extPrev_reg   <= extSample_reg;
    end
  end

  // One edge per sample pair, polarity by edge select
  assign extEdge = !sleepMode && (phase_reg == PHASE_TWO || phase_reg == PHASE_FOUR)
                   && (edgeSelect ? (extPrev_reg && !extSample_reg)
                                  : (!extPrev_reg && extSample_reg));
  assign sourceEvent = countSource ? extEdge : instrTick;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler sharing
  assign preTick  = assignWatchdog ? instrTick : sourceEvent;
  assign preClear = assignWatchdog ? watchdogClearInstr : countWrite;

  ebt_prescaler #(
    .WIDTH (PRESCALE_WIDTH)
  ) u_prescaler (
    .clk         (clk),
    .rst         (rst),
    .tick        (preTick),
    .clear       (preClear),
    .rate        (rate),
    .forWatchdog (assignWatchdog),
    .tapOut      (preOut)
  );

  // Undivided counting only when the watchdog owns the prescaler
  assign countEvent   = assignWatchdog ? sourceEvent : preOut;
  assign watchdogTick = assignWatchdog ? preOut : instrTick;

  ////////////////////////////////////////////////////////////////////////////
  // Count register with write inhibit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      inhibit_reg <= 2'h0;
    else if (countWrite)
      inhibit_reg <= WRITE_INHIBIT_CYCLES;
    else if (instrTick && inhibit_reg != 2'h0)
      inhibit_reg <= inhibit_reg - 2'h1;
  end

  assign overflow = countEvent && !countWrite && (inhibit_reg == 2'h0)
                    && (timerCount_reg == 8'hFF);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timerCount_reg <= COUNT_RESET;
    else if (countWrite)
      timerCount_reg <= wrData;
    else if (countEvent && inhibit_reg == 2'h0)
      timerCount_reg <= timerCount_reg + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and interrupt control
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timerConfig_reg <= CONFIG_RESET;
    else if (wrStrobe && addr == ADDR_CONFIG)
      timerConfig_reg <= wrData;
  end

  // Overflow set wins over a simultaneous software clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      interruptControl_reg <= INTCTL_RESET;
    else
    begin
      if (wrStrobe && addr == ADDR_INTCTL)
        interruptControl_reg <= wrData;
      if (overflow)
        interruptControl_reg[ICR_IF_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= interruptControl_reg[ICR_IF_BIT]
                 && interruptControl_reg[ICR_IE_BIT];
  end
  assign timerIrq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Minimal watchdog counter so the shared prescaler has a consumer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_reg <= '0;
      timeout_reg  <= 1'b0;
    end
    else if (watchdogClearInstr)
    begin
      watchdog_reg <= '0;
      timeout_reg  <= 1'b0;
    end
    else if (watchdogTick)
    begin
      watchdog_reg <= watchdog_reg + WATCHDOG_WIDTH'(1);
      if (watchdog_reg == '1)
        timeout_reg <= 1'b1;
    end
  end
  assign watchdogTimeout = timeout_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data valid one cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdData_reg <= 8'h00;
    else if (rdStrobe)
    begin
      case (addr)
        ADDR_CONFIG: rdData_reg <= timerConfig_reg;
        ADDR_INTCTL: rdData_reg <= interruptControl_reg;
        ADDR_COUNT:  rdData_reg <= timerCount_reg;
        default:     rdData_reg <= {7'h00, timeout_reg};
      endcase
    end
    else
      rdData_reg <= 8'h00;
  end
  assign rdData = rdData_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_flag_on_wrap: assert property (@(posedge clk) disable iff (rst)
    overflow |=> interruptControl_reg[ICR_IF_BIT])
    else $error("overflow flag not set after wrap");

  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    interruptControl_reg[ICR_IF_BIT] && !(wrStrobe && addr == ADDR_INTCTL)
    |=> interruptControl_reg[ICR_IF_BIT])
    else $error("overflow flag cleared by hardware");

  a_irq_gated: assert property (@(posedge clk) disable iff (rst)
    timerIrq |-> $past(interruptControl_reg[ICR_IF_BIT] && interruptControl_reg[ICR_IE_BIT]))
    else $error("interrupt without flag and enable");

  a_sleep_frozen: assert property (@(posedge clk) disable iff (rst)
    sleepMode && !countWrite |=> $stable(timerCount_reg))
    else $error("count changed during sleep");

  a_write_inhibit: assert property (@(posedge clk) disable iff (rst)
    countWrite ##1 (!countWrite)[*7] |-> $stable(timerCount_reg) || sleepMode)
    else $error("count moved inside write inhibit");

  a_wrap_zero: assert property (@(posedge clk) disable iff (rst)
    overflow |=> timerCount_reg == 8'h00)
    else $error("count did not wrap to zero");

  a_timer_rate: assert property (@(posedge clk) disable iff (rst)
    !countSource && assignWatchdog && !countWrite && inhibit_reg == 2'h0 && !sleepMode
    && phase_reg == PHASE_LAST |=> timerCount_reg == $past(timerCount_reg) + 8'h01)
    else $error("timer missed an instruction cycle");

  a_ext_sampled: assert property (@(posedge clk) disable iff (rst)
    phase_reg != PHASE_TWO && phase_reg != PHASE_FOUR |=> $stable(extSample_reg))
    else $error("external input sampled off phase");

  a_prescale_clear: assert property (@(posedge clk) disable iff (rst)
    countWrite && !assignWatchdog |=> u_prescaler.count_reg == '0)
    else $error("prescaler not cleared by count write");

  a_prescale_wd_clear: assert property (@(posedge clk) disable iff (rst)
    watchdogClearInstr && assignWatchdog |=> u_prescaler.count_reg == '0)
    else $error("prescaler not cleared by watchdog clear");

  a_timeout_cleared: assert property (@(posedge clk) disable iff (rst)
    watchdogClearInstr |=> !watchdogTimeout && watchdog_reg == '0)
    else $error("watchdog not cleared");

  a_irq_follows: assert property (@(posedge clk) disable iff (rst)
    interruptControl_reg[ICR_IF_BIT] && interruptControl_reg[ICR_IE_BIT] |=> timerIrq)
    else $error("interrupt missing for flag and enable");

  a_irq_masked: assert property (@(posedge clk) disable iff (rst)
    !interruptControl_reg[ICR_IE_BIT] |=> !timerIrq)
    else $error("interrupt raised while disabled");

  a_flag_no_spurious: assert property (@(posedge clk) disable iff (rst)
    !interruptControl_reg[ICR_IF_BIT] && !overflow && !(wrStrobe && addr == ADDR_INTCTL)
    |=> !interruptControl_reg[ICR_IF_BIT])
    else $error("overflow flag set without a wrap");

  a_count_write_lands: assert property (@(posedge clk) disable iff (rst)
    countWrite |=> timerCount_reg == $past(wrData))
    else $error("count write not taken");

  a_inhibit_load: assert property (@(posedge clk) disable iff (rst)
    countWrite |=> inhibit_reg == WRITE_INHIBIT_CYCLES)
    else $error("write inhibit not armed");

  ////////////////////////////////////////////////////////////////////////////
  // Check-only count of instruction cycles since the last count write, kept apart
  // from the inhibit counter so that a fault there cannot hide itself
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ticksSinceWrite_reg <= WRITE_INHIBIT_CYCLES;
    else if (countWrite)
      ticksSinceWrite_reg <= 2'h0;
    else if (instrTick && ticksSinceWrite_reg != WRITE_INHIBIT_CYCLES)
      ticksSinceWrite_reg <= ticksSinceWrite_reg + 2'h1;
  end

  a_inhibit_window: assert property (@(posedge clk) disable iff (rst)
    !countWrite && ticksSinceWrite_reg != WRITE_INHIBIT_CYCLES |=> $stable(timerCount_reg))
    else $error("count moved within two cycles of a write");

  a_ext_source_only: assert property (@(posedge clk) disable iff (rst)
    countSource && !extEdge && !countWrite |=> $stable(timerCount_reg))
    else $error("counter mode counted without an input edge");

  a_rise_ignored: assert property (@(posedge clk) disable iff (rst)
    countSource && edgeSelect && !extPrev_reg && extSample_reg && !countWrite
    |=> $stable(timerCount_reg))
    else $error("rising edge counted with falling edge selected");

  a_fall_ignored: assert property (@(posedge clk) disable iff (rst)
    countSource && !edgeSelect && extPrev_reg && !extSample_reg && !countWrite
    |=> $stable(timerCount_reg))
    else $error("falling edge counted with rising edge selected");

  a_timer_divided: assert property (@(posedge clk) disable iff (rst)
    !assignWatchdog && !u_prescaler.count_reg[0] |-> !countEvent)
    else $error("timer counted undivided with prescaler assigned");

  a_watchdog_unshared: assert property (@(posedge clk) disable iff (rst)
    !assignWatchdog |-> watchdogTick == instrTick)
    else $error("watchdog divided while prescaler serves the timer");

  a_watchdog_undivided: assert property (@(posedge clk) disable iff (rst)
    assignWatchdog && rate == 3'h0 |-> watchdogTick == instrTick)
    else $error("watchdog not undivided at rate code zero");

  a_sleep_no_wrap: assert property (@(posedge clk) disable iff (rst)
    sleepMode |-> !overflow)
    else $error("overflow during sleep");

  a_phase_frozen: assert property (@(posedge clk) disable iff (rst)
    sleepMode |=> $stable(phase_reg))
    else $error("instruction phase ran during sleep");

  a_ext_sleep: assert property (@(posedge clk) disable iff (rst)
    sleepMode |=> $stable(extSample_reg))
    else $error("external input sampled during sleep");
endmodule // ebt_timer

// >>> tb/ebt_count_source.sv
// External count pin source driven beside the timer under test
`timescale 1ns/1ps
module ebt_count_source (
  input  wire logic clk,
  output logic      pinLevel
);
  initial pinLevel = 1'b0;
  // Each level is held 13 clocks so that both phase samples see it
  task automatic toggle(input int n);
    repeat (n)
    begin
      @(posedge clk);
      pinLevel <= ~pinLevel;
      repeat (12) @(posedge clk);
    end
  endtask
endmodule // ebt_count_source

// >>> tb/ebt_timer_tb.sv
// Self-checking bench for the eight-bit timer with shared prescaler
`timescale 1ns/1ps
module ebt_timer_tb;
  import ebt_pkg::*;
  logic       clk                = 1'b0;
  logic       rst                = 1'b1;
  logic [1:0] addr               = 2'h0;
  logic [7:0] wrData             = 8'h00;
  logic       wrStrobe           = 1'b0;
  logic       rdStrobe           = 1'b0;
  logic       watchdogClearInstr = 1'b0;
  logic       sleepMode          = 1'b0;
  logic [7:0] rdData;
  logic       extCountInput;
  logic       timerIrq;
  logic       watchdogTimeout;
  logic [7:0] v0;
  logic [7:0] v1;
  int         n_errors           = 0;
  int         samples_checked    = 0;
  int         seed               = 32'h76cea72d;

  always #10 clk = ~clk;

  ebt_timer dut (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .extCountInput(extCountInput),
    .watchdogClearInstr(watchdogClearInstr), .sleepMode(sleepMode),
    .timerIrq(timerIrq), .watchdogTimeout(watchdogTimeout)
  );
  ebt_count_source src (.clk(clk), .pinLevel(extCountInput));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] dv);
    @(posedge clk);
    addr <= a;
    wrData <= dv;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 q = rdData;
  endtask
  task automatic chkrd(input logic [1:0] a, input logic [7:0] e, input string what);
    rd(a, v1);
    chk(what, e, v1);
  endtask
  // Count gained over a window of w clocks between two reads
  task automatic delta(input logic [7:0] cfg, input int w, input logic [7:0] e);
    wr(ADDR_CONFIG, cfg);
    repeat (40) @(posedge clk);
    rd(ADDR_COUNT, v0);
    repeat (w - 2) @(posedge clk);
    rd(ADDR_COUNT, v1);
    chk("count delta", e, v1 - v0);
  endtask
  // The 400 clocks after a count write hold exactly 100 ticks; the first two are inhibited
  task automatic wrrun(input logic [7:0] nv);
    wr(ADDR_COUNT, nv);
    repeat (399) @(posedge clk);
    rd(ADDR_COUNT, v1);
    chk("count after write", 8'd98, v1 - nv);
  endtask
  task automatic cnt(input logic [7:0] cfg, input logic [7:0] e);
    wr(ADDR_CONFIG, cfg);
    repeat (20) @(posedge clk);
    rd(ADDR_COUNT, v0);
    src.toggle(5);
    rd(ADDR_COUNT, v1);
    chk("edge count", e, v1 - v0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (50000) @(posedge clk);
    n_errors++;
    $display("mismatch run length expected end seen timeout");
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chkrd(ADDR_CONFIG, CONFIG_RESET, "config reset");
    chkrd(ADDR_INTCTL, INTCTL_RESET, "intctl reset");
    chkrd(ADDR_COUNT, COUNT_RESET, "count reset");
    @(posedge clk);
    watchdogClearInstr <= 1'b1;
    @(posedge clk);
    watchdogClearInstr <= 1'b0;
    chkrd(ADDR_WDSTAT, 8'h00, "watchdog status");
    chk("watchdog timeout", 8'h00, {7'h00, watchdogTimeout});
    cnt(8'h28, 8'd3);
    cnt(8'h38, 8'd3);
    cnt(8'h38, 8'd2);
    for (int c = 0; c < 8; c++)
      delta({5'h00, c[2:0]}, 1024, 8'(128 >> c));
    delta(8'h08, 400, 8'd100);
    for (int i = 0; i < 3; i++)
      wrrun(8'($random(seed)));
    wr(ADDR_CONFIG, 8'h07);
    chkrd(ADDR_CONFIG, 8'h07, "config readback");
    // A stale prescaler would tick before 225 instruction cycles pass
    for (int i = 0; i < 3; i++)
    begin
      repeat (($random(seed) & 255) + 1) @(posedge clk);
      wr(ADDR_COUNT, 8'h00);
      repeat (898) @(posedge clk);
      chkrd(ADDR_COUNT, 8'h00, "prescaled count");
    end
    wr(ADDR_CONFIG, 8'h08);
    wr(ADDR_INTCTL, 8'h20);
    wrrun(8'hFE);
    chkrd(ADDR_INTCTL, 8'h24, "overflow flag");
    chk("irq high", 8'h01, {7'h00, timerIrq});
    repeat (200) @(posedge clk);
    chkrd(ADDR_INTCTL, 8'h24, "flag kept");
    wr(ADDR_INTCTL, 8'h04);
    repeat (3) @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, timerIrq});
    wr(ADDR_INTCTL, 8'h20);
    chkrd(ADDR_INTCTL, 8'h20, "flag cleared");
    chk("irq cleared", 8'h00, {7'h00, timerIrq});
    @(posedge clk);
    sleepMode <= 1'b1;
    rd(ADDR_COUNT, v0);
    repeat (300) @(posedge clk);
    chkrd(ADDR_COUNT, v0, "sleep count");
    sleepMode <= 1'b0;
    tally_and_finish();
  end
endmodule // ebt_timer_tb
